/* link_status_regs.sv */
// Top of the link status and pin zero register slice with read/write decode and checks
`timescale 1ns/1ps
`default_nettype none
module link_status_regs (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Register access port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Control bits held elsewhere
    input wire logic crc_reset_in,
    input wire logic second_port_select_in,
    // Link events per port
    input wire link_status_pkg::port_events_type port0_ev_in,
    input wire link_status_pkg::port_events_type port1_ev_in,
    // Asynchronous detector and pin levels
    input wire logic pixel_clock_detect_in,
    input wire logic general_pin_zero_in,
    input wire logic second_port_pin_zero_in,
    // Pin drives
    output logic general_pin_zero_out,
    output logic general_pin_zero_oe_out,
    output logic second_port_pin_zero_out,
    output logic second_port_pin_zero_oe_out,
    // Filtered pin levels
    output logic general_pin_zero_level_out,
    output logic second_port_pin_zero_level_out
);
    import link_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    ////////////////////////////////////////////////////////////////////////////////
    logic [2:0] async_in;     // Pixel detect, pin zero, second pin zero
    logic [2:0] sync1_r;      // First stage, read only by second stage
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] agree;        // Second and third stages match
    logic [2:0] stable_r;     // Accepted levels
    logic [2:0] stable_nxt;

    assign async_in = {second_port_pin_zero_in, general_pin_zero_in, pixel_clock_detect_in};
    assign agree = ~(sync2_r ^ sync3_r);
    assign stable_nxt = (agree & sync3_r) | (~agree & stable_r);

    // Three-stage chain with agreement filter
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            stable_r <= 3'h0;
        end else if (ce_in) begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= stable_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-port units
    ////////////////////////////////////////////////////////////////////////////////
    port_status_type st0;     // First link status
    port_status_type st1;     // Second link status
    logic [3:0] cfg0;         // First pin config
    logic [3:0] cfg1;         // Second pin config
    pin_drive_type drv0;
    pin_drive_type drv1;
    logic clear0;             // CRC reset toward first link
    logic clear1;             // CRC reset toward second link
    logic cfg_we0;
    logic cfg_we1;
    logic hit_cfg;

    // Port select steers clear and config writes
    assign hit_cfg = (reg_addr_in == OFF_PIN_CFG);
    assign clear0 = crc_reset_in & ~second_port_select_in;
    assign clear1 = crc_reset_in & second_port_select_in;
    assign cfg_we0 = reg_wr_in & hit_cfg & ~second_port_select_in;
    assign cfg_we1 = reg_wr_in & hit_cfg & second_port_select_in;

    // First link
    port_status_unit u_port0 (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .ev_in(port0_ev_in),
        .clear_in(clear0),
        .cfg_we_in(cfg_we0),
        .cfg_wdata_in(reg_wdata_in[3:0]),
        .status_out(st0),
        .cfg_out(cfg0),
        .drive_out(drv0)
    );

    // Second link
    port_status_unit u_port1 (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .ev_in(port1_ev_in),
        .clear_in(clear1),
        .cfg_we_in(cfg_we1),
        .cfg_wdata_in(reg_wdata_in[3:0]),
        .status_out(st1),
        .cfg_out(cfg1),
        .drive_out(drv1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read path
    ////////////////////////////////////////////////////////////////////////////////
    port_status_type sel_st;  // Status of the selected link
    logic [3:0] sel_cfg;      // Config of the selected pin
    logic [7:0] status_byte;
    logic [7:0] cfg_byte;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;

    assign sel_st = second_port_select_in ? st1 : st0;
    assign sel_cfg = second_port_select_in ? cfg1 : cfg0;
    assign status_byte = {3'h0, sel_st.link_lost, sel_st.st_err, stable_r[0],
                          sel_st.rem_err, sel_st.link_det};
    assign cfg_byte = {REVISION_ID, sel_cfg};
    // Unmapped addresses read as zero
    assign rdata_nxt = (reg_addr_in == OFF_COUNT_LO) ? sel_st.count[7:0] :
                       (reg_addr_in == OFF_COUNT_HI) ? sel_st.count[15:8] :
                       (reg_addr_in == OFF_STATUS) ? status_byte :
                       hit_cfg ? cfg_byte : RDATA_RESET;

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= RDATA_RESET;
            rvalid_r <= 1'b0;
        end else if (ce_in) begin
            rvalid_r <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////////
    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;
    assign general_pin_zero_out = drv0.value;
    assign general_pin_zero_oe_out = drv0.oe;
    assign second_port_pin_zero_out = drv1.value;
    assign second_port_pin_zero_oe_out = drv1.oe;
    assign general_pin_zero_level_out = stable_r[1];
    assign second_port_pin_zero_level_out = stable_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////////

    // Error pulse below saturation adds one to the count
    property p_count_inc;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && port0_ev_in.crc_err && !clear0 && st0.count != COUNT_MAX)
        |=> (st0.count == $past(st0.count) + 16'h0001);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count did not advance");

    // Reset without error empties the count
    property p_count_clear;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && clear0 && !port0_ev_in.crc_err) |=> (st0.count == COUNT_RESET);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared");

    // Selected port's status appears on the next read answer
    property p_status_select;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && reg_rd_in && reg_addr_in == OFF_STATUS)
        |=> (reg_rvalid_out && reg_rdata_out[BIT_LINK_LOST] ==
             $past(second_port_select_in ? st1.link_lost : st0.link_lost));
    endproperty
    a_status_select: assert property (p_status_select) else $error("wrong port in status");

    // Link loss sets the flag, which then stays without a clear
    sequence s_link_drop;
        ce_in && port0_ev_in.link_detect ##1 ce_in && !port0_ev_in.link_detect;
    endsequence
    property p_link_lost;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_link_drop |=> st0.link_lost ##1 (st0.link_lost || $past(clear0));
    endproperty
    a_link_lost: assert property (p_link_lost) else $error("link lost flag missing");

    // Error during self-test raises the self-test flag
    property p_st_err;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && port1_ev_in.crc_err && port1_ev_in.bist_active) |=> st1.st_err;
    endproperty
    a_st_err: assert property (p_st_err) else $error("self-test flag not set");

    // Self-test restart clears a standing flag
    property p_st_restart;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && port1_ev_in.bist_start && !port1_ev_in.crc_err) |=> !st1.st_err;
    endproperty
    a_st_restart: assert property (p_st_restart) else $error("self-test flag kept");

    // Stable detector level reaches the status byte within the filter delay
    property p_pclk;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && pixel_clock_detect_in)[*5] |-> status_byte[BIT_PCLK_DET];
    endproperty
    a_pclk: assert property (p_pclk) else $error("pixel clock detect lagging");

    // Normal-traffic error raises the remote error flag
    property p_rem_err;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && port0_ev_in.crc_err && !port0_ev_in.bist_active) |=> st0.rem_err;
    endproperty
    a_rem_err: assert property (p_rem_err) else $error("remote error flag not set");

    // Software output mode drives the stored value
    property p_sw_out;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && cfg0[2:0] == MODE_SW_OUT)
        |=> (general_pin_zero_oe_out && general_pin_zero_out == $past(cfg0[BIT_PIN_VALUE]));
    endproperty
    a_sw_out: assert property (p_sw_out) else $error("pin not driven from value bit");

    // Readable input mode releases the pin
    property p_sw_in;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && cfg0[2:0] == MODE_SW_IN) |=> !general_pin_zero_oe_out;
    endproperty
    a_sw_in: assert property (p_sw_in) else $error("input mode drives pin");

    // Remote-default mode falls back to the stored value without link
    property p_rem_dflt;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && cfg0[2:0] == MODE_REM_DFLT && !port0_ev_in.link_detect)
        |=> (general_pin_zero_oe_out && general_pin_zero_out == $past(cfg0[BIT_PIN_VALUE]));
    endproperty
    a_rem_dflt: assert property (p_rem_dflt) else $error("default value not used");

    // Remote-hold mode keeps the pin steady while the link is down
    property p_rem_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && cfg0[2:0] == MODE_REM_HOLD && !port0_ev_in.link_detect)[*2]
        |=> $stable(general_pin_zero_out);
    endproperty
    a_rem_hold: assert property (p_rem_hold) else $error("held value moved");

    // Config write with the second port selected lands only in the second pin
    property p_cfg_route;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && reg_wr_in && hit_cfg && second_port_select_in)
        |=> (cfg1 == $past(reg_wdata_in[3:0]) && $stable(cfg0));
    endproperty
    a_cfg_route: assert property (p_cfg_route) else $error("config write misrouted");

    // Writes elsewhere leave both configs alone
    property p_ro_write;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (reg_wr_in && !hit_cfg) |=> ($stable(cfg0) && $stable(cfg1));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

    // Link loss without a new error clears both error flags
    property p_loss_clears;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_link_drop ##0 !port0_ev_in.crc_err |=> (!st0.rem_err && !st0.st_err);
    endproperty
    a_loss_clears: assert property (p_loss_clears) else $error("flags kept after loss");

    // Status read of the first link returns its live link level
    property p_link_det_read;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (ce_in && reg_rd_in && reg_addr_in == OFF_STATUS && !second_port_select_in)
        |=> (reg_rdata_out[BIT_LINK_DET] == $past(port0_ev_in.link_detect));
    endproperty
    a_link_det_read: assert property (p_link_det_read) else $error("link detect bit wrong");

    // Low enable freezes the count and the read answer
    property p_ce_freeze;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !ce_in |=> ($stable(st0.count) && $stable(reg_rvalid_out) && $stable(reg_rdata_out));
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
endmodule
`default_nettype wire

/* link_status_pkg.sv */
// Package with offsets, fields, reset values and carrier types for the link status register slice
// Function
// - Sixteen-bit back-channel CRC error count, two bytes
// - CRC reset control bit clears the count
// - Port select shows second link's counters, status
// - Link-lost flag sticks until CRC reset
// - Self-test CRC error flag, cleared by loss/restart/reset
// - Pixel clock detect bit follows input clock
// - Remote error flag on normal-traffic CRC errors
// - Link detect bit follows cable link state
// - Stored output value drives pin in output mode
// - Decode mode: input, high-z, output, readable input
// - Mode 101 drives remote value, holds on loss
// - Mode 111 drives remote, stored value on loss
// - Port select redirects pin config access to second pin
package link_status_pkg;
    // Register offsets
    localparam logic [7:0] OFF_COUNT_LO = 8'h0a;
    localparam logic [7:0] OFF_COUNT_HI = 8'h0b;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_PIN_CFG = 8'h0d;
    // Status byte bit positions
    localparam int BIT_LINK_DET = 0;
    localparam int BIT_REM_ERR = 1;
    localparam int BIT_PCLK_DET = 2;
    localparam int BIT_ST_ERR = 3;
    localparam int BIT_LINK_LOST = 4;
    // Pin config field positions
    localparam int BIT_PIN_VALUE = 3;
    localparam int BIT_REV_LO = 4;
    // Pin mode codes
    localparam logic [2:0] MODE_SW_OUT = 3'h1;
    localparam logic [2:0] MODE_SW_IN = 3'h3;
    localparam logic [2:0] MODE_REM_HOLD = 3'h5;
    localparam logic [2:0] MODE_REM_DFLT = 3'h7;
    // Reset values and the count saturation limit
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [3:0] PIN_CFG_RESET = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // Revision field, value is arbitrary
    localparam logic [3:0] REVISION_ID = 4'h1;

    // Per-port events from the link logic, same clock
    typedef struct packed {
        logic crc_err;      // One-cycle back-channel CRC error pulse
        logic bist_active;  // Self-test running, level
        logic bist_start;   // Self-test (re)start pulse
        logic link_detect;  // Cable link present, level
        logic remote_pin;   // Pin value received from far end
    } port_events_type;

    // Per-port status seen by the register read path
    typedef struct packed {
        logic [15:0] count;
        logic link_lost;
        logic st_err;
        logic rem_err;
        logic link_det;
    } port_status_type;

    // Pin drive pair
    typedef struct packed {
        logic value;
        logic oe;
    } pin_drive_type;
endpackage

/* port_status_unit.sv */
// Per-port error counter, sticky status flags and pin zero configuration and drive
`timescale 1ns/1ps
`default_nettype none
module port_status_unit (
    // Clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Link events and controls
    input wire link_status_pkg::port_events_type ev_in,
    input wire logic clear_in,
    input wire logic cfg_we_in,
    input wire logic [3:0] cfg_wdata_in,
    // Results
    output var link_status_pkg::port_status_type status_out,
    output logic [3:0] cfg_out,
    output var link_status_pkg::pin_drive_type drive_out
);
    import link_status_pkg::*;

    logic [15:0] count_r;       // Error count
    logic [15:0] count_nxt;
    logic [15:0] count_inc;     // Saturating increment
    logic link_prev_r;          // Link level one cycle back
    logic link_fall;            // Link loss event
    logic link_lost_r;
    logic link_lost_nxt;
    logic st_err_r;
    logic st_err_nxt;
    logic rem_err_r;
    logic rem_err_nxt;
    logic [3:0] cfg_r;          // Output value and mode
    logic [2:0] mode;
    logic held_r;               // Last remote value while linked
    logic remote_val;
    logic drv_val_nxt;
    logic drv_oe_nxt;
    pin_drive_type drive_r;

    // Next-state terms; an event in the clear cycle wins
    assign link_fall = link_prev_r & ~ev_in.link_detect;
    assign count_inc = (count_r == COUNT_MAX) ? COUNT_MAX : count_r + 16'h0001;
    assign count_nxt = ev_in.crc_err ? (clear_in ? 16'h0001 : count_inc)
                                     : (clear_in ? COUNT_RESET : count_r);
    assign link_lost_nxt = link_fall | (link_lost_r & ~clear_in);
    assign st_err_nxt = (ev_in.crc_err & ev_in.bist_active)
                      | (st_err_r & ~(link_fall | ev_in.bist_start | clear_in));
    assign rem_err_nxt = (ev_in.crc_err & ~ev_in.bist_active)
                       | (rem_err_r & ~(link_fall | clear_in));

    // Pin mode decode
    assign mode = cfg_r[2:0];
    assign drv_oe_nxt = mode[0] & (mode[2] | ~mode[1]);
    assign remote_val = ev_in.link_detect ? ev_in.remote_pin
                      : (mode[1] ? cfg_r[BIT_PIN_VALUE] : held_r);
    assign drv_val_nxt = mode[2] ? remote_val : cfg_r[BIT_PIN_VALUE];

    // Counter and flags
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= COUNT_RESET;
            link_prev_r <= 1'b0;
            link_lost_r <= 1'b0;
            st_err_r <= 1'b0;
            rem_err_r <= 1'b0;
        end else if (ce_in) begin
            count_r <= count_nxt;
            link_prev_r <= ev_in.link_detect;
            link_lost_r <= link_lost_nxt;
            st_err_r <= st_err_nxt;
            rem_err_r <= rem_err_nxt;
        end
    end

    // Configuration, held remote value and pin drive
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_r <= PIN_CFG_RESET;
            held_r <= 1'b0;
            drive_r <= '0;
        end else if (ce_in) begin
            if (cfg_we_in) begin
                cfg_r <= cfg_wdata_in;
            end
            if (ev_in.link_detect) begin
                held_r <= ev_in.remote_pin;
            end
            drive_r <= '{value: drv_val_nxt, oe: drv_oe_nxt};
        end
    end

    // Result ports
    assign status_out = '{count: count_r, link_lost: link_lost_r, st_err: st_err_r,
                          rem_err: rem_err_r, link_det: ev_in.link_detect};
    assign cfg_out = cfg_r;
    assign drive_out = drive_r;
endmodule
`default_nettype wire

/* remote_link_model.sv */
// Behavioural far-end partner that drives the per-port link event streams
`timescale 1ns/1ps
`default_nettype none
module remote_link_model (
    // Clock
    input wire logic ref_clk_in,
    // Event streams toward the slice
    output var link_status_pkg::port_events_type port0_ev_out,
    output var link_status_pkg::port_events_type port1_ev_out
);
    import link_status_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Bit positions inside the packed event struct, msb first
    localparam int F_CRC = 4;
    localparam int F_BIST = 3;
    localparam int F_START = 2;
    localparam int F_LINK = 1;
    localparam int F_REM = 0;
    // No link, no traffic at time zero
    initial begin
        port0_ev_out = '0;
        port1_ev_out = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Change one event field just after the next rising edge
    task automatic set_field(input int port, input int idx, input logic v);
        @(posedge ref_clk_in);
        if (port == 0) begin
            port0_ev_out[idx] <= v;
        end else begin
            port1_ev_out[idx] <= v;
        end
    endtask
    // Back-to-back error pulses, one per edge, n edges long
    task automatic crc_burst(input int port, input int n);
        set_field(port, F_CRC, 1'b1);
        repeat (n - 1) @(posedge ref_clk_in);
        set_field(port, F_CRC, 1'b0);
    endtask
endmodule
`default_nettype wire

/* link_status_regs_tb.sv */
// Self-checking bench for the link status and pin zero register slice
`timescale 1ns/1ps
`default_nettype none
module link_status_regs_tb;
    import link_status_pkg::*;
    // Bench-driven inputs and the read data output
    logic ref_clk, rst_n, reg_wr, reg_rd, crc_reset, port_sel, pclk_det, gp_ext, sp_ext, ce;
    logic [7:0] reg_addr, reg_wdata, rdata;
    // Design outputs
    logic rvalid, gp_out, gp_oe, sp_out, sp_oe, gp_lvl, sp_lvl;
    // Resolved pin wires, the driver wins while enabled
    wire logic gp_wire = gp_oe ? gp_out : gp_ext;
    wire logic sp_wire = sp_oe ? sp_out : sp_ext;
    port_events_type ev0, ev1;
    int errors, checked;
    ////////////////////////////////////////////////////////////////////////////////
    // Far-end partner and the slice
    remote_link_model remote_link_model_inst (.ref_clk_in(ref_clk), .port0_ev_out(ev0), .port1_ev_out(ev1));
    link_status_regs link_status_regs_inst (
        .ref_clk_in(ref_clk), .rst_n_in(rst_n), .ce_in(ce),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .crc_reset_in(crc_reset), .second_port_select_in(port_sel),
        .port0_ev_in(ev0), .port1_ev_in(ev1),
        .pixel_clock_detect_in(pclk_det), .general_pin_zero_in(gp_wire), .second_port_pin_zero_in(sp_wire),
        .general_pin_zero_out(gp_out), .general_pin_zero_oe_out(gp_oe),
        .second_port_pin_zero_out(sp_out), .second_port_pin_zero_oe_out(sp_oe),
        .general_pin_zero_level_out(gp_lvl), .second_port_pin_zero_level_out(sp_lvl)
    );
    // Free-running 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, answer lands one cycle later
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check({7'h0, rvalid, rdata}, {8'h01, exp});
    endtask
    // Pulse the clear control on the selected port
    task automatic pulse_clear;
        @(posedge ref_clk);
        crc_reset <= 1'b1;
        @(posedge ref_clk);
        crc_reset <= 1'b0;
    endtask
    // Change the port select level
    task automatic select(input logic v);
        @(posedge ref_clk);
        port_sel <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, read-only writes ignored, unmapped read
    task automatic test_reset;
        reg_write(OFF_PIN_CFG, 8'hf0);
        expect_reg(OFF_COUNT_LO, 8'h00);
        expect_reg(OFF_COUNT_HI, 8'h00);
        expect_reg(OFF_STATUS, 8'h00);
        expect_reg(OFF_PIN_CFG, {REVISION_ID, 4'h0});
        expect_reg(8'h0e, 8'h00);
    endtask
    // Count across the byte boundary, per-port view, clear
    task automatic test_count;
        remote_link_model_inst.set_field(0, 1, 1'b1);
        remote_link_model_inst.set_field(1, 1, 1'b1);
        remote_link_model_inst.crc_burst(0, 258);
        remote_link_model_inst.crc_burst(1, 5);
        expect_reg(OFF_COUNT_LO, 8'h02);
        expect_reg(OFF_COUNT_HI, 8'h01);
        expect_reg(OFF_STATUS, 8'h03);
        reg_write(OFF_COUNT_LO, 8'hff);
        reg_write(OFF_STATUS, 8'hff);
        expect_reg(OFF_COUNT_LO, 8'h02);
        expect_reg(OFF_STATUS, 8'h03);
        select(1'b1);
        expect_reg(OFF_COUNT_LO, 8'h05);
        expect_reg(OFF_COUNT_HI, 8'h00);
        pulse_clear();
        expect_reg(OFF_COUNT_LO, 8'h00);
        expect_reg(OFF_STATUS, 8'h01);
        select(1'b0);
        pulse_clear();
        expect_reg(OFF_COUNT_HI, 8'h00);
    endtask
    // Sticky loss flag and the self-test error flag
    task automatic test_flags;
        remote_link_model_inst.set_field(0, 3, 1'b1);
        remote_link_model_inst.crc_burst(0, 1);
        expect_reg(OFF_STATUS, 8'h09);
        remote_link_model_inst.set_field(0, 2, 1'b1);
        remote_link_model_inst.set_field(0, 2, 1'b0);
        expect_reg(OFF_STATUS, 8'h01);
        remote_link_model_inst.crc_burst(0, 1);
        remote_link_model_inst.set_field(0, 3, 1'b0);
        remote_link_model_inst.crc_burst(0, 1);
        remote_link_model_inst.set_field(0, 1, 1'b0);
        expect_reg(OFF_STATUS, 8'h10);
        remote_link_model_inst.set_field(0, 1, 1'b1);
        expect_reg(OFF_STATUS, 8'h11);
        pulse_clear();
        expect_reg(OFF_STATUS, 8'h01);
        @(posedge ref_clk);
        pclk_det <= 1'b1;
        repeat (6) @(posedge ref_clk);
        expect_reg(OFF_STATUS, 8'h05);
        @(posedge ref_clk);
        pclk_det <= 1'b0;
        repeat (6) @(posedge ref_clk);
        expect_reg(OFF_STATUS, 8'h01);
    endtask
    // Every mode code, then the two remote modes across a link loss
    task automatic test_pins;
        for (int m = 0; m < 8; m++) begin
            reg_write(OFF_PIN_CFG, {5'h01, m[2:0]});
            repeat (3) @(posedge ref_clk);
            check({14'h0, gp_oe, gp_oe & gp_out}, {14'h0, m[0] && m[2:0] != MODE_SW_IN, m == 1});
        end
        gp_ext <= 1'b1;
        reg_write(OFF_PIN_CFG, {5'h00, MODE_SW_IN});
        repeat (6) @(posedge ref_clk);
        check({15'h0, gp_lvl}, 16'h0001);
        remote_link_model_inst.set_field(0, 0, 1'b1);
        reg_write(OFF_PIN_CFG, {5'h00, MODE_REM_HOLD});
        repeat (3) @(posedge ref_clk);
        check({14'h0, gp_oe, gp_out}, 16'h0003);
        remote_link_model_inst.set_field(0, 1, 1'b0);
        remote_link_model_inst.set_field(0, 0, 1'b0);
        repeat (3) @(posedge ref_clk);
        check({14'h0, gp_oe, gp_out}, 16'h0003);
        reg_write(OFF_PIN_CFG, {5'h00, MODE_REM_DFLT});
        repeat (3) @(posedge ref_clk);
        check({14'h0, gp_oe, gp_out}, 16'h0002);
        remote_link_model_inst.set_field(0, 1, 1'b1);
        remote_link_model_inst.set_field(0, 0, 1'b1);
        repeat (3) @(posedge ref_clk);
        check({14'h0, gp_oe, gp_out}, 16'h0003);
    endtask
    // Port select redirects configuration to the second pin
    task automatic test_second_pin;
        select(1'b1);
        reg_write(OFF_PIN_CFG, 8'hf9);
        repeat (3) @(posedge ref_clk);
        check({14'h0, sp_oe, sp_out}, 16'h0003);
        expect_reg(OFF_PIN_CFG, {REVISION_ID, 4'h9});
        check({15'h0, sp_lvl}, 16'h0001);
        select(1'b0);
        expect_reg(OFF_PIN_CFG, {REVISION_ID, 1'b0, MODE_REM_DFLT});
        // Frozen enable: error pulses leave the count alone
        @(posedge ref_clk);
        ce <= 1'b0;
        remote_link_model_inst.crc_burst(0, 3);
        @(posedge ref_clk);
        ce <= 1'b1;
        expect_reg(OFF_COUNT_LO, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 12 cycles, then every scenario
    initial begin
        errors = 0;
        checked = 0;
        {rst_n, reg_wr, reg_rd, crc_reset, port_sel, pclk_det, gp_ext, sp_ext} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ce = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_count();
        test_flags();
        test_pins();
        test_second_pin();
        summarize();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
